// ==== verilog/dcc_top.sv ====
// digital channel conditioning: polarity, delays, modes, fault response, apb registers
//
// Summary of operation
// R1: channel polarity selectable: signal passed unchanged or inverted.
// R2: normal mode forwards the conditioned field value.
// R3: simulation mode forwards the simulation value instead of field signal.
// R4: simulation value is one configurable bit, zero or one.
// R5: simulation with invalid status triggers the fault response like a real fault.
// R6: current-value error mode keeps forwarding the present value during a fault.
// R7: substitute error mode forwards the configured substitute bit during a fault.
// R8: substitute value carries configurable status qualifier, valid or invalid.
// R9: last-valid mode holds the value valid just before the fault.
// R10: enabled line fault detection on break or short gives diagnosis and response.
// R11: line fault enable honoured only for two-wire proximity-sensor channels.
// R12: rising transitions delayed by configurable milliseconds; shorter pulses suppressed.
// R13: falling transitions delayed by configurable milliseconds; high pulses stretched.
// R14: module error reporting flags module and global status when enabled.
// R15: channel fault reports slot, channel, input/output id and reason.
// R16: values and status delivered at a fixed 6.5 ms period.
// R17: input byte bit 1 shows line fault of valve output, 1 is error.
// R18: delays counted by a millisecond tick; zero delay passes immediately.
// R19: last valid value captured every fault-free cycle, frozen when fault starts.
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module dcc_top
  import dcc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int UPDATE_CYCLES = UPDATE_CYCLES_DEF
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  output logic [DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic field_in_i,
  input wire logic sensor_namur_i,
  input wire logic fault_break_i,
  input wire logic fault_short_i,
  output logic chan_value_o,
  output logic chan_ok_o,
  output logic update_o,
  output logic [7:0] input_byte_o,
  output logic chan_fault_o,
  output logic module_error_o,
  output logic global_error_o,
  output logic [SLOT_W-1:0] err_slot_o,
  output logic [CHAN_W-1:0] err_chan_o,
  output logic err_io_o,
  output logic [1:0] err_reason_o
);

  function automatic logic dcc_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction : dcc_hit

  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] delay_reg;
  logic [CNT_W-1:0] tick_cnt_reg;
  logic [CNT_W-1:0] upd_cnt_reg;
  logic [DLY_W-1:0] dly_cnt_reg;
  logic filt_reg;
  logic last_reg;

  // register decode and apb handshake
  wire logic hit_ctrl_w = dcc_hit(paddr_i, CTRL_OFF);
  wire logic hit_delay_w = dcc_hit(paddr_i, DELAY_OFF);
  wire logic hit_status_w = dcc_hit(paddr_i, STATUS_OFF);
  wire logic hit_diag_w = dcc_hit(paddr_i, DIAG_OFF);
  wire logic hit_w = hit_ctrl_w | hit_delay_w | hit_status_w | hit_diag_w;
  wire logic access_w = psel_i && penable_i && !pready_o;
  wire logic done_w = psel_i && penable_i && pready_o;
  wire logic wr_w = done_w && pwrite_i;

  // configuration fields
  wire logic pol_neg_w = ctrl_reg[CTRL_POL_BIT];
  wire logic sim_mode_w = ctrl_reg[CTRL_SIM_BIT];
  wire logic sim_val_w = ctrl_reg[CTRL_SIMVAL_BIT];
  wire logic sim_bad_cfg_w = ctrl_reg[CTRL_SIMBAD_BIT];
  wire dcc_emode_t emode_w = dcc_emode_t'(ctrl_reg[CTRL_EMODE_LSB +: 2]);
  wire logic sub_val_w = ctrl_reg[CTRL_SUBVAL_BIT];
  wire logic sub_ok_w = ctrl_reg[CTRL_SUBOK_BIT];
  wire logic lfd_en_w = ctrl_reg[CTRL_LFD_BIT];
  wire logic modrep_w = ctrl_reg[CTRL_MODREP_BIT];
  wire logic [DLY_W-1:0] on_dly_w = delay_reg[DELAY_ON_LSB +: DLY_W];
  wire logic [DLY_W-1:0] off_dly_w = delay_reg[DELAY_OFF_LSB +: DLY_W];

  // millisecond tick and delivery period
  wire logic tick_w = tick_cnt_reg == CNT_W'(TICK_CYCLES - 1); // see R18
  wire logic upd_w = upd_cnt_reg == CNT_W'(UPDATE_CYCLES - 1); // see R16

  // polarity, then on/off delay filter
  wire logic pol_w = field_in_i ^ pol_neg_w; // see R1
  wire logic differ_w = pol_w != filt_reg;
  wire logic [DLY_W-1:0] dly_sel_w = pol_w ? on_dly_w : off_dly_w; // see R12 // see R13
  wire logic dly_zero_w = dly_sel_w == '0;
  wire logic filt_take_w = differ_w && (dly_zero_w || (tick_w && dly_cnt_reg >= dly_sel_w)); // see R18

  // fault sources
  wire logic lfd_active_w = lfd_en_w && sensor_namur_i; // see R11
  wire logic line_break_w = lfd_active_w && fault_break_i;
  wire logic line_short_w = lfd_active_w && fault_short_i;
  wire logic line_fault_w = line_break_w || line_short_w; // see R10
  wire logic sim_bad_w = sim_mode_w && sim_bad_cfg_w; // see R5
  wire logic fault_w = line_fault_w || sim_bad_w;
  wire logic [1:0] reason_w = line_break_w ? RSN_BREAK : line_short_w ? RSN_SHORT :
                              sim_bad_w ? RSN_SIM : RSN_NONE; // see R15

  // mode and error-mode selection
  wire logic mode_value_w = sim_mode_w ? sim_val_w : filt_reg; // see R2 // see R3 // see R4
  wire logic out_value_w = !fault_w ? mode_value_w :
                           (emode_w == DCC_EM_SUBST) ? sub_val_w : // see R7
                           (emode_w == DCC_EM_LAST) ? last_reg : // see R9
                           mode_value_w; // see R6
  wire logic out_ok_w = !fault_w || ((emode_w == DCC_EM_SUBST) && sub_ok_w); // see R8

  wire logic [DATA_W-1:0] status_w = {26'h0, filt_reg, line_short_w, line_break_w, fault_w, out_ok_w, out_value_w};
  wire logic [DATA_W-1:0] diag_w = {ctrl_reg[CTRL_IO_BIT], 1'b0, reason_w, 4'h0,
                                    ctrl_reg[CTRL_CHAN_LSB +: CHAN_W], ctrl_reg[CTRL_SLOT_LSB +: SLOT_W], 12'h0};
  wire logic [DATA_W-1:0] rd_data_w = hit_ctrl_w ? ctrl_reg :
                                      hit_delay_w ? delay_reg :
                                      hit_status_w ? status_w :
                                      hit_diag_w ? diag_w : '0;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end else if (enable_i) begin
      pready_o <= access_w;
      pslverr_o <= access_w && !hit_w;
      if (access_w) begin
        prdata_o <= pwrite_i ? '0 : rd_data_w;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ctrl_reg <= CTRL_RESET;
      delay_reg <= DELAY_RESET;
    end else if (enable_i && wr_w) begin
      if (hit_ctrl_w) begin
        ctrl_reg <= pwdata_i;
      end else if (hit_delay_w) begin
        delay_reg <= pwdata_i;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tick_cnt_reg <= '0;
      upd_cnt_reg <= '0;
    end else if (enable_i) begin
      tick_cnt_reg <= tick_w ? '0 : tick_cnt_reg + 1'b1;
      upd_cnt_reg <= upd_w ? '0 : upd_cnt_reg + 1'b1;
    end
  end

  // counts whole ticks while the input differs from the filtered level
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      filt_reg <= 1'b0;
      dly_cnt_reg <= '0;
    end else if (enable_i) begin
      if (filt_take_w) begin
        filt_reg <= pol_w;
      end
      if (!differ_w || filt_take_w) begin
        dly_cnt_reg <= '0;
      end else if (tick_w) begin
        dly_cnt_reg <= dly_cnt_reg + 1'b1; // see R12 // see R13
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      last_reg <= 1'b0;
    end else if (enable_i && !fault_w) begin
      last_reg <= mode_value_w; // see R19
    end
  end

  // periodic delivery toward the communication unit
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      chan_value_o <= 1'b0;
      chan_ok_o <= 1'b0;
      update_o <= 1'b0;
      input_byte_o <= '0;
    end else if (enable_i) begin
      update_o <= upd_w;
      if (upd_w) begin
        chan_value_o <= out_value_w; // see R16
        chan_ok_o <= out_ok_w;
        input_byte_o <= '0;
        input_byte_o[IB_VALVE_BIT] <= out_value_w;
        input_byte_o[IB_LINE_BIT] <= line_fault_w; // see R17
      end
    end
  end

  // diagnosis follows the fault each cycle
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      chan_fault_o <= 1'b0;
      module_error_o <= 1'b0;
      global_error_o <= 1'b0;
      err_slot_o <= '0;
      err_chan_o <= '0;
      err_io_o <= 1'b0;
      err_reason_o <= RSN_NONE;
    end else if (enable_i) begin
      chan_fault_o <= fault_w; // see R10
      module_error_o <= fault_w && modrep_w; // see R14
      global_error_o <= fault_w && modrep_w;
      err_slot_o <= ctrl_reg[CTRL_SLOT_LSB +: SLOT_W]; // see R15
      err_chan_o <= ctrl_reg[CTRL_CHAN_LSB +: CHAN_W];
      err_io_o <= ctrl_reg[CTRL_IO_BIT];
      err_reason_o <= reason_w;
    end
  end

  default clocking dcc_cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);

  zero_delay_pass_a: assert property ( // see R18
    (enable_i && on_dly_w == '0 && off_dly_w == '0 && $stable(ctrl_reg) && $stable(delay_reg))
    |=> filt_reg == $past(pol_w))
    else $error("zero delay did not pass polarised input");

  sequence rise_pending_s;
    enable_i && !filt_reg && pol_w && on_dly_w != '0 && dly_cnt_reg == '0 && !tick_w;
  endsequence
  on_delay_hold_a: assert property (rise_pending_s |=> !filt_reg) // see R12
    else $error("rising edge passed before on delay");

  sequence fall_pending_s;
    enable_i && filt_reg && !pol_w && off_dly_w != '0 && dly_cnt_reg == '0 && !tick_w;
  endsequence
  off_delay_hold_a: assert property (fall_pending_s |=> filt_reg) // see R13
    else $error("falling edge passed before off delay");

  sim_select_a: assert property ((sim_mode_w && !fault_w) |-> out_value_w == sim_val_w) // see R3
    else $error("simulation value not forwarded");

  sim_invalid_fault_a: assert property ((enable_i && sim_mode_w && sim_bad_cfg_w) |=> chan_fault_o) // see R5
    else $error("invalid simulation status raised no fault");

  subst_output_a: assert property ( // see R7
    (fault_w && emode_w == DCC_EM_SUBST) |-> (out_value_w == sub_val_w && out_ok_w == sub_ok_w))
    else $error("substitute value or status wrong");

  last_valid_hold_a: assert property ( // see R9
    (enable_i && fault_w && emode_w == DCC_EM_LAST) |=> (fault_w && emode_w == DCC_EM_LAST) |->
    (out_value_w == last_reg && $stable(last_reg)))
    else $error("last valid value not held");

  line_fault_gate_a: assert property (line_fault_w |-> (lfd_en_w && sensor_namur_i)) // see R11
    else $error("line fault accepted without namur enable");

  module_global_a: assert property (module_error_o == global_error_o) // see R14
    else $error("module and global error differ");

  sequence upd_pulse_s;
    enable_i && upd_w;
  endsequence
  update_latch_a: assert property ( // see R16
    upd_pulse_s |=> (update_o && chan_value_o == $past(out_value_w) && input_byte_o[IB_LINE_BIT] == $past(line_fault_w)))
    else $error("periodic update did not latch value");

  apb_ready_a: assert property ((enable_i && access_w) |=> pready_o ##1 (!pready_o || !$past(enable_i)))
    else $error("apb ready not a single pulse");

  // clock enable low must freeze the channel state and the delivery pulse
  freeze_hold_a: assert property (
    !enable_i |=> ($stable(filt_reg) && $stable(dly_cnt_reg) && $stable(ctrl_reg) && $stable(last_reg) && $stable(update_o)))
    else $error("state moved while enable was low");

  normal_mode_a: assert property ((!sim_mode_w && !fault_w) |-> out_value_w == filt_reg) // see R2
    else $error("field value not forwarded in normal mode");

  current_mode_a: assert property ( // see R6
    (fault_w && emode_w != DCC_EM_SUBST && emode_w != DCC_EM_LAST) |-> (out_value_w == mode_value_w && !out_ok_w))
    else $error("current value not forwarded during fault");

  line_fault_diag_a: assert property ((enable_i && line_fault_w) |=> chan_fault_o) // see R10
    else $error("line fault raised no diagnosis");

  module_error_a: assert property ((enable_i && fault_w && modrep_w) |=> module_error_o) // see R14
    else $error("module error not flagged");

  reason_break_a: assert property ((enable_i && line_break_w) |=> err_reason_o == RSN_BREAK) // see R15
    else $error("break reason not reported");

  last_capture_a: assert property ((enable_i && !fault_w) |=> last_reg == $past(mode_value_w)) // see R19
    else $error("last valid value not captured");

endmodule : dcc_top

// ==== verilog/dcc_pkg.sv ====
// constants, field layout and modes of the digital channel conditioning block
package dcc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DLY_W = 16;
  localparam int CNT_W = 24;

  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] DELAY_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] DIAG_OFF = 8'h0c;

  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DELAY_RESET = 32'h0000_0000;

  localparam int CTRL_POL_BIT = 0;
  localparam int CTRL_SIM_BIT = 1;
  localparam int CTRL_SIMVAL_BIT = 2;
  localparam int CTRL_SIMBAD_BIT = 3;
  localparam int CTRL_EMODE_LSB = 4;
  localparam int CTRL_SUBVAL_BIT = 6;
  localparam int CTRL_SUBOK_BIT = 7;
  localparam int CTRL_LFD_BIT = 8;
  localparam int CTRL_MODREP_BIT = 9;
  localparam int CTRL_SLOT_LSB = 16;
  localparam int CTRL_CHAN_LSB = 24;
  localparam int CTRL_IO_BIT = 28;
  localparam int SLOT_W = 8;
  localparam int CHAN_W = 4;
  localparam int DELAY_ON_LSB = 0;
  localparam int DELAY_OFF_LSB = 16;

  localparam int IB_VALVE_BIT = 0;
  localparam int IB_LINE_BIT = 1;

  localparam logic [1:0] RSN_NONE = 2'h0;
  localparam logic [1:0] RSN_BREAK = 2'h1;
  localparam logic [1:0] RSN_SHORT = 2'h2;
  localparam logic [1:0] RSN_SIM = 2'h3;

  typedef enum logic [1:0] {DCC_EM_CURRENT, DCC_EM_SUBST, DCC_EM_LAST} dcc_emode_t;

  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_TIME_NS = 1000000;
  localparam int TICK_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int UPDATE_TIME_US = 6500;
  localparam int UPDATE_CYCLES_DEF = UPDATE_TIME_US * 1000 / CLK_PERIOD_NS;
endpackage : dcc_pkg

// ==== test/dcc_comm_unit.sv ====
// model of the communication unit: takes channel data at each update pulse
`timescale 1ns/1ps
module dcc_comm_unit (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic update_i,
  input wire logic value_i,
  input wire logic ok_i,
  input wire logic [7:0] byte_i,
  output logic took_o,
  output logic [17:0] data_o
);
  logic [7:0] gap_reg;
  always_ff @(posedge clock_i) begin
    took_o <= 1'b0;
    gap_reg <= gap_reg + 8'h01;
    if (reset_i) begin
      gap_reg <= 8'h00;
      data_o <= 18'h0;
    end else if (update_i) begin
      took_o <= 1'b1;
      data_o <= {gap_reg + 8'h01, value_i, ok_i, byte_i};
      gap_reg <= 8'h00;
    end
  end
endmodule : dcc_comm_unit

// ==== test/tb_digital_channel_conditioning.sv ====
// self-checking bench of the channel conditioning block
`timescale 1ns/1ps
module tb_digital_channel_conditioning;
  import dcc_pkg::*;
  typedef struct {logic k; logic [35:0] m; logic [35:0] e;} dcc_note_t;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] fi = 4'h0;
  logic en = 1'b1;
  logic pready, pslverr, value, ok, upd, flt, merr, gerr, took, held, eio;
  logic [7:0] ibyte, eslot;
  logic [3:0] echan;
  logic [1:0] ersn;
  logic [17:0] pdat;
  logic [35:0] got;
  logic [31:0] seed = 32'h0000_7f40;
  logic [3:0] ft [6] = '{4'h3, 4'h7, 4'hb, 4'hf, 4'h3, 4'h5};
  logic [1:0] rt [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h3, 2'h0};
  dcc_note_t q[$];
  dcc_note_t n;
  int n_errors = 0, compares = 0, cyc = 0;

  dcc_top #(.TICK_CYCLES(4), .UPDATE_CYCLES(16)) DUT (.clock_i(clock_i), .reset_i(reset_i),
    .enable_i(en), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .field_in_i(fi[0]), .sensor_namur_i(fi[1]), .fault_break_i(fi[2]), .fault_short_i(fi[3]),
    .chan_value_o(value), .chan_ok_o(ok), .update_o(upd), .input_byte_o(ibyte),
    .chan_fault_o(flt), .module_error_o(merr), .global_error_o(gerr), .err_slot_o(eslot),
    .err_chan_o(echan), .err_io_o(eio), .err_reason_o(ersn));
  dcc_comm_unit partner (.clock_i(clock_i), .reset_i(reset_i), .update_i(upd), .value_i(value),
    .ok_i(ok), .byte_i(ibyte), .took_o(took), .data_o(pdat));

  always #4 clock_i = ~clock_i;

  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nxt

  task automatic finish_test();
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (pready !== 1'b1) @(posedge clock_i);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] m, input logic [32:0] e);
    q.push_back('{1'b0, {3'h0, m}, {3'h0, e}});
    apb(1'b0, a, 32'h0);
  endtask : rd

  // configures the channel, freezes it briefly, lets it settle and notes the next delivery
  task automatic apply(input logic [31:0] c, input logic [31:0] dl, input logic [3:0] f);
    logic lv, v, okv, ln, fl;
    logic [1:0] rsn;
    @(posedge clock_i);
    fi <= f;
    apb(1'b1, DELAY_OFF, dl);
    apb(1'b1, CTRL_OFF, c);
    en <= 1'b0;
    repeat (nxt() % 8 + 1) @(posedge clock_i);
    en <= 1'b1;
    lv = c[1] ? c[2] : f[0] ^ c[0];
    ln = c[8] & f[1] & (f[2] | f[3]);
    fl = ln | (c[1] & c[3]);
    rsn = (ln & f[2]) ? RSN_BREAK : (ln & f[3]) ? RSN_SHORT : (c[1] & c[3]) ? RSN_SIM : RSN_NONE;
    v = lv;
    okv = ~fl;
    if (!fl) held = lv;
    else if (c[5:4] == 2'h1) begin
      v = c[6];
      okv = c[7];
    end else if (c[5:4] == 2'h2) v = held;
    repeat (4) @(posedge clock_i iff upd);
    q.push_back('{1'b1, 36'hf_ffff_ffff,
                  {c[28], rsn, c[27:24], c[23:16], 8'h10, v, okv, 6'h0, ln, v, fl & c[9], fl & c[9], fl}});
    while (q.size() > 0) @(posedge clock_i);
  endtask : apply

  always @(posedge clock_i) begin
    if (q.size() > 0 && ((!q[0].k && psel && penable && pready && !pwrite) || (q[0].k && took))) begin
      got = q[0].k ? {eio, ersn, echan, eslot, pdat, gerr, merr, flt} : {3'h0, pslverr, prdata};
      n = q.pop_front();
      compares++;
      if ((got & n.m) !== (n.e & n.m)) begin
        n_errors++;
        $display("[FAIL] %s exp %h got %h", n.k ? "delivery" : "read", n.e & n.m, got & n.m);
      end
    end
  end

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 10000) begin
      n_errors++;
      $display("[FAIL] timeout exp %0d got %0d", 10000, cyc);
      finish_test();
    end
  end

  initial begin
    logic [31:0] r, c;
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    rd(CTRL_OFF, 33'h1_ffff_ffff, 33'h0);
    rd(DELAY_OFF, 33'h1_ffff_ffff, 33'h0);
    rd(8'h10, 33'h1_ffff_ffff, 33'h1_0000_0000);
    apb(1'b1, CTRL_OFF, 32'hffff_ffff);
    rd(CTRL_OFF, 33'h1_1fff_03ff, 33'h0_1fff_03ff);
    apb(1'b1, STATUS_OFF, 32'h0);
    rd(STATUS_OFF, 33'h1_0000_0004, 33'h0_0000_0004);
    for (int i = 0; i < 24; i++) begin
      r = nxt();
      c = {3'h0, r[28:16], 6'h0, r[9:6], r[4] ? 2'h1 : {r[5], r[5]}, r[3:0]};
      apply(c, 32'h0, r[13:10]);
    end
    apply(32'h0000_0320, 32'h0, 4'h3);
    apply(32'h0000_0320, 32'h0, 4'h6);
    apply(32'h0000_0320, 32'h0, 4'h2);
    for (int k = 0; k < 6; k++) begin
      r = nxt();
      c = {3'h0, r[28:16], 16'h0310} | (k == 4 ? 32'ha : 32'h0);
      apply(c, 32'h0, ft[k]);
      rd(DIAG_OFF, 33'h1_ffff_ffff, {1'b0, c[28], 1'b0, rt[k], 4'h0, c[27:24], c[23:16], 12'h0});
    end
    apply(32'h0, 32'h0000_0006, 4'h0);
    fi <= 4'h1;
    repeat (16) @(posedge clock_i);
    rd(STATUS_OFF, 33'h20, 33'h0);
    fi <= 4'h0;
    apply(32'h0, 32'h0000_0006, 4'h0);
    apply(32'h0, 32'h0000_0006, 4'h1);
    apply(32'h0, 32'h0006_0000, 4'h1);
    fi <= 4'h0;
    repeat (16) @(posedge clock_i);
    rd(STATUS_OFF, 33'h20, 33'h20);
    apply(32'h0, 32'h0006_0000, 4'h0);
    apply(32'h0, 32'h0, 4'h0);
    fi <= 4'h1;
    rd(STATUS_OFF, 33'h20, 33'h20);
    repeat (2) @(posedge clock_i);
    if (q.size() != 0) begin
      n_errors++;
      $display("[FAIL] pending notes exp %0d got %0d", 0, q.size());
    end
    finish_test();
  end
endmodule : tb_digital_channel_conditioning
